// File: hw/adc_control_register_bank.v
// control register bank of a dual-channel converter with shadowed settings
`timescale 1ns/10ps
`include "adc_ctrl_defs.vh"

module adc_control_register_bank #(
  parameter DATA_W = 16
) (
  input wire sys_clk_in,
  input wire rst_in,
  input wire soft_reset_in,
  input wire [7:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire reg_write_in,
  input wire reg_read_in,
  output reg [7:0] reg_rdata_out,
  output reg reg_rvalid_out,
  input wire power_down_pin_in,
  input wire [2*DATA_W-1:0] conv_data_in,
  output wire [2*DATA_W-1:0] data_out,
  output reg [1:0] full_power_down_out,
  output reg [1:0] standby_out,
  output reg duty_stabilizer_out,
  output reg [2:0] clock_ratio_out,
  output reg clock_tick_out,
  output reg self_test_enable_out,
  output reg self_test_reset_out,
  output reg servo_enable_out
);

  // ==========================================================
  // shadow (written) copies and global settings
  reg [1:0] channel_select;
  reg stab_shadow;
  reg [2:0] ratio_shadow;
  reg [1:0] self_test_shadow;
  reg servo_shadow;
  reg [2:0] tick_count;
  wire [15:0] power_shadow_w;
  wire [15:0] pattern_shadow_w;
  wire commit = reg_write_in && (reg_addr_in == `ADDR_SHADOW_COMMIT) &&
    reg_wdata_in[`COMMIT_BIT];
  // self-test defaults split per bit so each live flop takes its own field
  localparam [1:0] SELF_TEST_DFLT = `RST_SELF_TEST;
  wire [1:0] next_full_down;
  wire [1:0] next_standby;

  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      channel_select <= `RST_CHANNEL_SELECT;
      stab_shadow <= `RST_DUTY_STABILIZER;
      ratio_shadow <= `RST_CLOCK_RATIO;
      self_test_shadow <= `RST_SELF_TEST;
      servo_shadow <= `RST_SERVO;
    end else if (soft_reset_in) begin
      channel_select <= `RST_CHANNEL_SELECT;
      stab_shadow <= `RST_DUTY_STABILIZER;
      ratio_shadow <= `RST_CLOCK_RATIO;
      self_test_shadow <= `RST_SELF_TEST;
      servo_shadow <= `RST_SERVO;
    end else if (reg_write_in) begin
      case (reg_addr_in)
        `ADDR_CHANNEL_SELECT: channel_select <= reg_wdata_in[1:0];
        `ADDR_DUTY_STABILIZER: stab_shadow <= reg_wdata_in[0];
        `ADDR_CLOCK_RATIO: ratio_shadow <= reg_wdata_in[2:0];
        `ADDR_SELF_TEST: self_test_shadow <= {reg_wdata_in[`SELF_TEST_RST_BIT],
          reg_wdata_in[`SELF_TEST_EN_BIT]};
        `ADDR_SERVO: servo_shadow <= reg_wdata_in[0];
        default: channel_select <= channel_select;
      endcase
    end
  end

  // ==========================================================
  // global live settings, loaded only on a transfer
  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      duty_stabilizer_out <= `RST_DUTY_STABILIZER;
      clock_ratio_out <= `RST_CLOCK_RATIO;
      self_test_reset_out <= SELF_TEST_DFLT[1];
      self_test_enable_out <= SELF_TEST_DFLT[0];
      servo_enable_out <= `RST_SERVO;
    end else if (soft_reset_in) begin
      duty_stabilizer_out <= `RST_DUTY_STABILIZER;
      clock_ratio_out <= `RST_CLOCK_RATIO;
      self_test_reset_out <= SELF_TEST_DFLT[1];
      self_test_enable_out <= SELF_TEST_DFLT[0];
      servo_enable_out <= `RST_SERVO;
    end else if (commit) begin
      // any divide other than one turns the stabilizer on regardless of its bit
      duty_stabilizer_out <= stab_shadow | (ratio_shadow != 3'h0);
      clock_ratio_out <= ratio_shadow;
      self_test_reset_out <= self_test_shadow[1];
      self_test_enable_out <= self_test_shadow[0];
      servo_enable_out <= servo_shadow;
    end
  end

  // ==========================================================
  // input clock divider: one tick every ratio plus one cycles
  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      tick_count <= 3'h0;
      clock_tick_out <= 1'b0;
    end else if (tick_count >= clock_ratio_out) begin
      tick_count <= 3'h0;
      clock_tick_out <= 1'b1;
    end else begin
      tick_count <= tick_count + 3'h1;
      clock_tick_out <= 1'b0;
    end
  end

  // ==========================================================
  // per-channel local registers, live copies and pattern sources
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : chan
      reg [2:0] power_shadow;
      reg [4:0] pattern_shadow;
      reg [2:0] power_live;
      reg [4:0] pattern_live;
      wire local_wr = reg_write_in && channel_select[ch];
      wire [1:0] mode = power_live[1:0];
      wire pin_full = power_down_pin_in && !power_live[2];
      wire pin_stby = power_down_pin_in && power_live[2];
      assign power_shadow_w[8*ch+:8] = {1'b1, 1'b0, power_shadow[2], 3'h0, power_shadow[1:0]};
      assign pattern_shadow_w[8*ch+:8] = {2'h0, pattern_shadow[4:3], 1'b0, pattern_shadow[2:0]};

      // soft reset is a synchronous input; feeding it into the async clear would
      // let a glitch on that pin wipe the settings
      always @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
          power_shadow <= 3'h0;
          pattern_shadow <= `RST_PATTERN_SELECT;
          power_live <= 3'h0;
          pattern_live <= `RST_PATTERN_SELECT;
        end else if (soft_reset_in) begin
          power_shadow <= 3'h0;
          pattern_shadow <= `RST_PATTERN_SELECT;
          power_live <= 3'h0;
          pattern_live <= `RST_PATTERN_SELECT;
        end else begin
          if (local_wr && reg_addr_in == `ADDR_POWER_STATE) begin
            power_shadow <= {reg_wdata_in[`POWER_PIN_FN_BIT], reg_wdata_in[`POWER_MODE_HI:0]};
          end
          if (local_wr && reg_addr_in == `ADDR_PATTERN_SELECT) begin
            pattern_shadow <= {reg_wdata_in[`PATTERN_LONG_RST_BIT],
              reg_wdata_in[`PATTERN_SHORT_RST_BIT], reg_wdata_in[`PATTERN_MODE_HI:0]};
          end
          if (commit) begin
            power_live <= power_shadow;
            pattern_live <= pattern_shadow;
          end
        end
      end

      assign next_full_down[ch] = (mode == `PWR_FULL_DOWN) | pin_full;
      // full power-down outranks standby when both are asked for
      assign next_standby[ch] = !next_full_down[ch] &&
        ((mode == `PWR_STANDBY) | pin_stby);

      output_pattern_source #(
        .DATA_W(DATA_W)
      ) src (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .conv_data_in(conv_data_in[DATA_W*ch+:DATA_W]),
        .mode_in(pattern_live[2:0]),
        .long_rst_in(pattern_live[4]),
        .short_rst_in(pattern_live[3]),
        .data_out(data_out[DATA_W*ch+:DATA_W])
      );
    end
  endgenerate

  // ==========================================================
  // power state outputs, one register stage behind the live settings
  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      full_power_down_out <= 2'h0;
      standby_out <= 2'h0;
    end else begin
      full_power_down_out <= next_full_down;
      standby_out <= next_standby;
    end
  end

  // ==========================================================
  // read port; shadow values read back, transfer always reads zero
  reg [7:0] next_rdata;
  // channel A wins when both bits are set
  wire rd_b = !channel_select[0] && channel_select[1];

  always @* begin
    case (reg_addr_in)
      `ADDR_CHANNEL_SELECT: next_rdata = {6'h00, channel_select};
      `ADDR_POWER_STATE: next_rdata = rd_b ? power_shadow_w[15:8] : power_shadow_w[7:0];
      `ADDR_DUTY_STABILIZER: next_rdata = {7'h00, stab_shadow};
      `ADDR_CLOCK_RATIO: next_rdata = {5'h00, ratio_shadow};
      `ADDR_PATTERN_SELECT: next_rdata = rd_b ? pattern_shadow_w[15:8] : pattern_shadow_w[7:0];
      `ADDR_SELF_TEST: next_rdata = {5'h00, self_test_shadow[1], 1'b0, self_test_shadow[0]};
      `ADDR_SERVO: next_rdata = {7'h00, servo_shadow};
      default: next_rdata = 8'h00;
    endcase
  end

  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      reg_rdata_out <= 8'h00;
      reg_rvalid_out <= 1'b0;
    end else begin
      reg_rvalid_out <= reg_read_in;
      if (reg_read_in) begin
        reg_rdata_out <= next_rdata;
      end
    end
  end

endmodule // adc_control_register_bank

// File: hw/adc_ctrl_defs.vh
// register offsets, field positions and reset values for the converter control bank
`ifndef ADC_CTRL_DEFS_VH
`define ADC_CTRL_DEFS_VH

// ==========================================================
// register offsets
`define ADDR_CHANNEL_SELECT 8'h05
`define ADDR_POWER_STATE 8'h08
`define ADDR_DUTY_STABILIZER 8'h09
`define ADDR_CLOCK_RATIO 8'h0b
`define ADDR_PATTERN_SELECT 8'h0d
`define ADDR_SELF_TEST 8'h0e
`define ADDR_SERVO 8'h0f
`define ADDR_SHADOW_COMMIT 8'hff

// ==========================================================
// reset values
`define RST_CHANNEL_SELECT 2'h3
`define RST_POWER_STATE 8'h80
`define RST_DUTY_STABILIZER 1'h1
`define RST_CLOCK_RATIO 3'h0
`define RST_PATTERN_SELECT 5'h00
`define RST_SELF_TEST 2'h2
`define RST_SERVO 1'h0

// ==========================================================
// field positions
`define POWER_FIXED_BIT 7
`define POWER_PIN_FN_BIT 5
`define POWER_MODE_HI 1
`define PATTERN_LONG_RST_BIT 5
`define PATTERN_SHORT_RST_BIT 4
`define PATTERN_MODE_HI 2
`define SELF_TEST_RST_BIT 2
`define SELF_TEST_EN_BIT 0
`define COMMIT_BIT 0

// ==========================================================
// encodings
`define PWR_FULL_DOWN 2'h1
`define PWR_STANDBY 2'h2
`define PAT_OFF 3'h0
`define PAT_MIDSCALE 3'h1
`define PAT_POS_FULL 3'h2
`define PAT_NEG_FULL 3'h3
`define PAT_CHECKER 3'h4
`define PAT_LONG_NOISE 3'h5
`define PAT_SHORT_NOISE 3'h6
`define PAT_WORD_TOGGLE 3'h7

// ==========================================================
// test words and noise generator shapes
`define WORD_MIDSCALE 16'h8000
`define WORD_POS_FULL 16'hffff
`define WORD_NEG_FULL 16'h0000
`define WORD_CHECKER_A 16'haaaa
`define WORD_CHECKER_B 16'h5555
`define LONG_NOISE_SEED 23'h7fffff
`define LONG_NOISE_TAP 17
`define SHORT_NOISE_SEED 9'h1ff
`define SHORT_NOISE_TAP 4

`endif

// File: hw/output_pattern_source.v
// per-channel output word source: conversion data or one of the test patterns
`timescale 1ns/10ps
`include "adc_ctrl_defs.vh"

module output_pattern_source #(
  parameter DATA_W = 16
) (
  input wire sys_clk_in,
  input wire rst_in,
  input wire [DATA_W-1:0] conv_data_in,
  input wire [2:0] mode_in,
  input wire long_rst_in,
  input wire short_rst_in,
  output reg [DATA_W-1:0] data_out
);

  reg [22:0] long_noise;
  reg [8:0] short_noise;
  reg phase;
  wire long_fb = long_noise[22] ^ long_noise[`LONG_NOISE_TAP];
  wire short_fb = short_noise[8] ^ short_noise[`SHORT_NOISE_TAP];
  reg [15:0] next_word;

  // ==========================================================
  // noise generators, held at seed while their reset bit stands
  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      long_noise <= `LONG_NOISE_SEED;
      short_noise <= `SHORT_NOISE_SEED;
      phase <= 1'b0;
    end else begin
      phase <= ~phase;
      if (long_rst_in) begin
        long_noise <= `LONG_NOISE_SEED;
      end else begin
        long_noise <= {long_noise[21:0], long_fb};
      end
      if (short_rst_in) begin
        short_noise <= `SHORT_NOISE_SEED;
      end else begin
        short_noise <= {short_noise[7:0], short_fb};
      end
    end
  end

  // ==========================================================
  // pattern select; test data replaces conversion data when mode is nonzero
  always @* begin
    case (mode_in)
      `PAT_OFF: next_word = conv_data_in[15:0];
      `PAT_MIDSCALE: next_word = `WORD_MIDSCALE;
      `PAT_POS_FULL: next_word = `WORD_POS_FULL;
      `PAT_NEG_FULL: next_word = `WORD_NEG_FULL;
      `PAT_CHECKER: next_word = phase ? `WORD_CHECKER_B : `WORD_CHECKER_A;
      `PAT_LONG_NOISE: next_word = long_noise[15:0];
      `PAT_SHORT_NOISE: next_word = {short_noise, short_noise[8:2]};
      `PAT_WORD_TOGGLE: next_word = phase ? `WORD_POS_FULL : `WORD_NEG_FULL;
      default: next_word = conv_data_in[15:0];
    endcase
  end

  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      data_out <= {DATA_W{1'b0}};
    end else begin
      data_out <= next_word[DATA_W-1:0];
    end
  end

endmodule // output_pattern_source

// File: test/reg_host_model.sv
// host side of the register port: one write or read per call
`timescale 1ns/10ps
module reg_host_model (
  input wire sys_clk_in,
  input wire rvalid_in,
  input wire [7:0] rdata_in,
  output logic [7:0] addr_out = 8'h00,
  output logic [7:0] wdata_out = 8'h00,
  output logic write_out = 1'b0,
  output logic read_out = 1'b0
);
  // =====
  // released lines show the inverse so a stale value cannot pass for a live one
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk_in);
    addr_out = a;
    wdata_out = d;
    write_out = 1'b1;
    @(negedge sys_clk_in);
    write_out = 1'b0;
    addr_out = ~a;
    wdata_out = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int n;
    @(negedge sys_clk_in);
    addr_out = a;
    read_out = 1'b1;
    @(negedge sys_clk_in);
    read_out = 1'b0;
    addr_out = ~a;
    for (n = 0; n < 3 && !rvalid_in; n++) @(negedge sys_clk_in);
    d = rdata_in;
  endtask
endmodule // reg_host_model

// File: test/adc_control_register_bank_checker.sv
// port assertions for the converter control bank
`timescale 1ns/10ps
module adc_bank_checker (
  input wire sys_clk_in,
  input wire rst_in,
  input wire soft_reset_in,
  input wire [7:0] reg_addr_in,
  input wire reg_write_in,
  input wire reg_read_in,
  input wire [7:0] reg_rdata_out,
  input wire reg_rvalid_out,
  input wire [1:0] full_power_down_out,
  input wire [1:0] standby_out,
  input wire duty_stabilizer_out,
  input wire [2:0] clock_ratio_out,
  input wire clock_tick_out,
  input wire self_test_enable_out,
  input wire self_test_reset_out,
  input wire servo_enable_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  // =====
  a_read_answer: assert property (reg_read_in |=> reg_rvalid_out)
    else $error("read not answered");
  a_no_stray: assert property (!reg_read_in |=> !reg_rvalid_out)
    else $error("read valid without request");
  a_commit_reads: assert property (reg_read_in && reg_addr_in == 8'hff |=>
    reg_rdata_out == 8'h00) else $error("transfer read not zero");
  a_live_held: assert property (
    reg_write_in && reg_addr_in != 8'hff && !soft_reset_in && !$past(soft_reset_in)
    && !($past(reg_write_in) && $past(reg_addr_in) == 8'hff) |=>
    $stable({clock_ratio_out, servo_enable_out, self_test_enable_out}))
    else $error("live setting moved without commit");
  a_power_excl: assert property ((full_power_down_out & standby_out) == 2'b00)
    else $error("power-down and standby together");
  a_stab_forced: assert property (clock_ratio_out != 3'h0 |-> duty_stabilizer_out)
    else $error("stabilizer off with divider");
  a_tick_div1: assert property (
    clock_ratio_out == 3'h0 && $stable(clock_ratio_out) && clock_tick_out && !soft_reset_in
    |=> clock_tick_out || clock_ratio_out != 3'h0) else $error("tick missed at divide 1");
  a_reset_vals: assert property ($fell(rst_in) |-> duty_stabilizer_out
    && self_test_reset_out && !self_test_enable_out) else $error("bad reset value");
endmodule // adc_bank_checker
bind adc_control_register_bank adc_bank_checker chk (.sys_clk_in, .rst_in, .soft_reset_in,
  .reg_addr_in, .reg_write_in, .reg_read_in, .reg_rdata_out, .reg_rvalid_out,
  .full_power_down_out, .standby_out, .duty_stabilizer_out, .clock_ratio_out,
  .clock_tick_out, .self_test_enable_out, .self_test_reset_out, .servo_enable_out);

// File: test/adc_control_register_bank_tb.sv
// self-checking bench for the converter control bank
`timescale 1ns/10ps
module adc_control_register_bank_tb;
  logic sys_clk_in = 0, rst_in = 1, soft_reset_in = 0, pin = 0;
  logic [31:0] conv = 32'h1234_4321;
  wire [7:0] addr, wdata, rdata;
  wire wr, rd, rvalid, stab, tick, st_en, st_rst, servo;
  wire [31:0] dout;
  wire [1:0] fpd, sb;
  wire [2:0] ratio;
  int n_mismatch = 0, compares = 0, cycles = 0, i;
  logic [31:0] k;
  logic [7:0] r;
  logic [15:0] w1, w2;
  logic [15:0] dflt [0:6] = '{16'h0503, 16'h0880, 16'h0901, 16'h0b00, 16'h0d00, 16'h0e04,
    16'h0f00};
  logic [23:0] rows [0:8] = '{24'h050101, 24'h0822a2, 24'h090000, 24'h0b0707, 24'h0d3535,
    24'h0e0101, 24'h0f0101, 24'h015a00, 24'hff0000};
  // the pin is global: channel b keeps its default pin function and goes full down
  logic [12:0] pw [0:5] = '{{8'h01, 5'h04}, {8'h02, 5'h01}, {8'h03, 5'h00}, {8'h00, 5'h1c},
    {8'h20, 5'h19}, {8'h20, 5'h00}};
  logic [23:0] pt [0:5] = '{24'h018000, 24'h02ffff, 24'h030000, 24'h004321, 24'h25ffff,
    24'h16ffff};
  always #5 sys_clk_in = ~sys_clk_in;
  reg_host_model host (.sys_clk_in(sys_clk_in), .rvalid_in(rvalid), .rdata_in(rdata),
    .addr_out(addr), .wdata_out(wdata), .write_out(wr), .read_out(rd));
  adc_control_register_bank uut (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .soft_reset_in(soft_reset_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_write_in(wr), .reg_read_in(rd), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
    .power_down_pin_in(pin), .conv_data_in(conv), .data_out(dout),
    .full_power_down_out(fpd), .standby_out(sb), .duty_stabilizer_out(stab),
    .clock_ratio_out(ratio), .clock_tick_out(tick), .self_test_enable_out(st_en),
    .self_test_reset_out(st_rst), .servo_enable_out(servo));
  // =====
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("counts: %0d compares, %0d mismatches", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // fixed wait: new mode reaches the outputs one edge after the commit edge
  task automatic commit;
    host.wr(8'hff, 8'h01);
    repeat (3) @(negedge sys_clk_in);
  endtask
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      end_sim();
    end
  end
  // =====
  initial begin
    repeat (20) @(negedge sys_clk_in);
    rst_in = 0;
    for (i = 0; i < 7; i++) begin
      host.rd(dflt[i][15:8], r);
      check(r, dflt[i][7:0]);
    end
    check({stab, st_rst, st_en, ratio, fpd, sb}, 10'h300);
    $display("defaults test done");
    for (i = 0; i < 9; i++) begin
      host.wr(rows[i][23:16], rows[i][15:8]);
      host.rd(rows[i][23:16], r);
      check(r, rows[i][7:0]);
    end
    check({ratio, servo, st_en, sb}, 7'h00);
    commit;
    check({ratio, stab, servo, st_en, st_rst, sb, fpd}, 11'h7e4);
    check(dout, 32'h1234ffff);
    k = 0;
    repeat (16) begin
      @(posedge sys_clk_in);
      #1 k += tick;
    end
    check(k, 2);
    $display("commit test done");
    for (i = 0; i < 6; i++) begin
      pin = pw[i][4];
      host.wr(8'h08, pw[i][12:5]);
      commit;
      check({fpd, sb}, pw[i][3:0]);
    end
    for (i = 0; i < 6; i++) begin
      host.wr(8'h0d, pt[i][23:16]);
      commit;
      check(dout, {16'h1234, pt[i][15:0]});
    end
    host.wr(8'h0d, 8'h04);
    commit;
    w1 = dout[15:0];
    @(negedge sys_clk_in) w2 = dout[15:0];
    // the board may start on either word
    check({w1 ^ w2, w1 == 16'haaaa || w1 == 16'h5555}, 17'h1ffff);
    host.wr(8'h0d, 8'h07);
    commit;
    w1 = dout[15:0];
    @(negedge sys_clk_in) w2 = dout[15:0];
    check({w1 ^ w2, w1 == 16'hffff || w1 == 16'h0000}, 17'h1ffff);
    // both generators held at seed, then released by one transfer: zeros shift in
    host.wr(8'h05, 8'h03);
    host.wr(8'h0d, 8'h36);
    commit;
    host.wr(8'h05, 8'h01);
    host.wr(8'h0d, 8'h05);
    host.wr(8'h05, 8'h02);
    host.wr(8'h0d, 8'h06);
    commit;
    check(dout, 32'hfe7ffffc);
    @(negedge sys_clk_in) check(dout, 32'hfc7efff8);
    $display("pattern test done");
    host.wr(8'h05, 8'h03);
    host.wr(8'h0d, 8'h03);
    host.wr(8'h05, 8'h02);
    host.wr(8'h0d, 8'h01);
    host.wr(8'h05, 8'h03);
    host.rd(8'h0d, r);
    check(r, 8'h03);
    host.wr(8'h05, 8'h02);
    host.rd(8'h0d, r);
    check(r, 8'h01);
    commit;
    check(dout, 32'h80000000);
    @(negedge sys_clk_in) soft_reset_in = 1;
    @(negedge sys_clk_in) soft_reset_in = 0;
    host.rd(8'h05, r);
    check(r, 8'h03);
    check({stab, st_rst, st_en, ratio, servo, fpd, sb}, 11'h600);
    check(dout, 32'h12344321);
    $display("channel and soft reset test done");
    end_sim();
  end
endmodule // adc_control_register_bank_tb
